// ===== src/serial_channel_pkg.sv
// constants shared by the serial channel design files
package serial_channel_pkg;
	localparam logic [2:0] MODE_OFF = 3'h0;
	localparam logic [2:0] MODE_TWO_WIRE = 3'h2;
	localparam logic [2:0] MODE_ASYNC7 = 3'h4;
	localparam logic [2:0] MODE_ASYNC8 = 3'h5;
	localparam logic [2:0] MODE_ASYNC9 = 3'h6;
	localparam int OVERSAMPLE = 16;
	localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
	localparam logic [3:0] SAMPLE_POINT = 4'h7;
	localparam logic [3:0] DELAY_MIN = 4'h2;
	localparam logic [3:0] DELAY_MAX = 4'h8;
	localparam logic [8:0] BUFFER_RESET = 9'h000;
	localparam int REF_CLK_MHZ = 50;
	typedef enum {ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP} frame_state_t;
endpackage

// ===== src/baud_tick_gen.sv
// baud divider producing one oversample tick per n+1 count source cycles
`timescale 1ns/100ps
module baud_tick_gen (
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic i_source_tick,
	input wire logic [7:0] i_baud_divider,
	output logic o_tick
);
	logic [7:0] count_r;

	// reload on reaching zero so any divider change takes effect at the next wrap
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			count_r <= 8'h00;
			o_tick <= 1'b0;
		end else begin
			o_tick <= 1'b0;
			if (i_source_tick) begin
				if (count_r == 8'h00) begin
					count_r <= i_baud_divider;
					o_tick <= 1'b1;
				end else begin
					count_r <= count_r - 8'h01;
				end
			end
		end
	end
endmodule

// ===== src/async_serial_channel.sv
// one asynchronous serial channel with two-wire mode support logic
// Overview of operation
// - characters use buffer bits 0-6, 0-7 or 0-8 for 7, 8, 9 bits
// - serial output idles high (low with line polarity inversion) after mode selection until a transfer starts
// - receive-only keeps output high (low with line polarity inversion); transmit-only frees the input pin
// - clock pin is port pin when internal clock, clock input when external
// - flow pin is port, clear-to-send input or request-to-send output
// - bit rate equals baud divider output divided by sixteen
// - writing rx_allow 0 then 1 resets the receive buffer state
// - mode off, mode on, then transmit_allow write clears transmit buffer
// - bit order select picks LSB or MSB first, only for 8-bit characters
// - data logic inversion flips written and read data bits
// - line polarity inversion flips every frame bit on both pins
// - clear-to-send high halts before the next character starts
// - request-to-send low when ready, high at first serial clock fall
// - split handshake needs specific settings on both channels
// - split handshake removes channel 1 separate flow control
// - two-wire mode is mode 010b with two-wire select set
// - two-wire data output changes only after clock is stably low
// - two-wire uses 8-bit characters; master clock divides by 2(n+1)
// - two-wire reception needs rx and tx allow and transmit data present
// - two-wire overrun at 8th bit before read; receive flag untouched
// - two-wire data delay is off or 2 to 8 count source cycles
// - software selects arbitration flag timing and clock delay
// - frame is start, 7-9 data, optional parity, one or two stops
// - async modes are 100b, 101b and 110b for 7, 8, 9 bits
`timescale 1ns/100ps
module async_serial_channel
	import serial_channel_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic i_source_tick,
	input wire logic [7:0] i_baud_divider,
	input wire logic [2:0] i_serial_mode_select,
	input wire logic i_two_wire_mode_select,
	input wire logic i_clock_source_external_select,
	input wire logic i_handshake_disable,
	input wire logic i_handshake_direction_select,
	input wire logic i_split_handshake_active,
	input wire logic i_bit_order_select,
	input wire logic i_data_logic_invert,
	input wire logic i_line_polarity_invert,
	input wire logic i_stop_bit_count_select,
	input wire logic i_parity_enable,
	input wire logic i_parity_odd,
	input wire logic i_clock_delay_select,
	input wire logic i_arbitration_update_select,
	input wire logic [3:0] i_data_delay_cycles,
	input wire logic i_transmit_allow,
	input wire logic i_transmit_allow_write,
	input wire logic i_rx_allow,
	input wire logic [8:0] i_tx_data,
	input wire logic i_tx_write,
	input wire logic i_rx_read,
	input wire logic i_serial_in_pin,
	input wire logic i_serial_clock_pin,
	input wire logic i_flow_control_pin,
	output logic o_serial_out_pin,
	output logic o_serial_out_pin_oe_n,
	output logic o_flow_control_pin,
	output logic o_flow_control_pin_oe_n,
	output logic o_serial_clock_is_input,
	output logic o_serial_in_is_port,
	output logic o_tx_buffer_empty_flag,
	output logic o_tx_shift_empty,
	output logic [8:0] o_rx_buffer,
	output logic o_rx_complete,
	output logic o_overrun_error,
	output logic o_framing_error,
	output logic o_parity_error,
	output logic o_two_wire_active,
	output logic o_arbitration_update_on_bit,
	output logic o_clock_delay_active
);
	logic async_mode;
	logic two_wire_mode;
	logic [3:0] char_bits;
	logic [8:0] data_mask;
	logic tick;
	logic [2:0] rxd_sync_r;
	logic [2:0] clk_sync_r;
	logic [2:0] cts_sync_r;
	logic rx_line_r;
	logic clk_pin_r;
	logic clk_pin_prev_r;
	logic cts_level_r;
	logic rx_line;
	logic cts_mode;
	logic rts_mode;
	logic rx_allow_prev_r;
	logic mode_was_off_r;
	logic [8:0] tx_buffer_r;
	logic tx_buffer_empty_r;
	frame_state_t tx_state_r;
	logic [3:0] tx_os_r;
	logic [3:0] tx_idx_r;
	logic [8:0] tx_shift_r;
	logic tx_stop2_r;
	logic tx_line_r;
	logic tx_parity_r;
	frame_state_t rx_state_r;
	logic [3:0] rx_os_r;
	logic [3:0] rx_idx_r;
	logic [8:0] rx_shift_r;
	logic rx_parity_r;
	logic rx_stop2_r;
	logic rx_full_r;
	logic rts_r;
	logic [3:0] low_count_r;
	logic delayed_out_r;
	logic [7:0] tx_rev;
	logic [7:0] rx_rev;

	assign async_mode = (i_serial_mode_select == MODE_ASYNC7) ||
		(i_serial_mode_select == MODE_ASYNC8) || (i_serial_mode_select == MODE_ASYNC9);
	assign two_wire_mode = (i_serial_mode_select == MODE_TWO_WIRE) && i_two_wire_mode_select;
	assign o_two_wire_active = two_wire_mode;

	// character width and the buffer bits it occupies
	always_comb begin
		if (two_wire_mode || i_serial_mode_select == MODE_ASYNC8) begin
			char_bits = 4'h8;
			data_mask = 9'h0FF;
		end else if (i_serial_mode_select == MODE_ASYNC9) begin
			char_bits = 4'h9;
			data_mask = 9'h1FF;
		end else begin
			char_bits = 4'h7;
			data_mask = 9'h07F;
		end
	end

	baud_tick_gen u_baud (
		.i_ref_clk(i_ref_clk),
		.i_reset_n(i_reset_n),
		.i_source_tick(i_source_tick),
		.i_baud_divider(i_baud_divider),
		.o_tick(tick)
	);

	// mirrored low byte for msb-first 8-bit characters, one wire per bit
	for (genvar g = 0; g < 8; g++) begin : g_rev
		assign tx_rev[g] = tx_buffer_r[7 - g];
		assign rx_rev[g] = rx_shift_r[7 - g];
	end

	// pin synchronisers: a change counts once stages two and three agree
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rxd_sync_r <= 3'h7;
			clk_sync_r <= 3'h7;
			cts_sync_r <= 3'h7;
			rx_line_r <= 1'b1;
			clk_pin_r <= 1'b1;
			clk_pin_prev_r <= 1'b1;
			cts_level_r <= 1'b1;
		end else begin
			rxd_sync_r <= {rxd_sync_r[1:0], i_serial_in_pin};
			clk_sync_r <= {clk_sync_r[1:0], i_serial_clock_pin};
			cts_sync_r <= {cts_sync_r[1:0], i_flow_control_pin};
			if (rxd_sync_r[1] == rxd_sync_r[2])
				rx_line_r <= rxd_sync_r[2];
			if (clk_sync_r[1] == clk_sync_r[2])
				clk_pin_r <= clk_sync_r[2];
			if (cts_sync_r[1] == cts_sync_r[2])
				cts_level_r <= cts_sync_r[2];
			clk_pin_prev_r <= clk_pin_r;
		end
	end

	assign rx_line = rx_line_r ^ i_line_polarity_invert;
	assign o_serial_clock_is_input = i_clock_source_external_select;
	assign cts_mode = !i_handshake_disable && !i_handshake_direction_select &&
		!i_split_handshake_active;
	assign rts_mode = !i_handshake_disable && i_handshake_direction_select &&
		!i_split_handshake_active;
	assign o_serial_in_is_port = (rx_state_r == ST_IDLE) && !i_rx_allow;
	assign o_arbitration_update_on_bit = two_wire_mode && i_arbitration_update_select;
	assign o_clock_delay_active = two_wire_mode && i_clock_delay_select;

	// clear sequence trackers: rx_allow rising, and mode passing through off
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rx_allow_prev_r <= 1'b0;
			mode_was_off_r <= 1'b0;
		end else begin
			rx_allow_prev_r <= i_rx_allow;
			if (i_serial_mode_select == MODE_OFF)
				mode_was_off_r <= 1'b1;
			else if (i_transmit_allow_write)
				mode_was_off_r <= 1'b0;
		end
	end

	// transmit holding buffer; data inversion applied on the way in
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tx_buffer_r <= BUFFER_RESET;
			tx_buffer_empty_r <= 1'b1;
		end else if (i_transmit_allow_write && mode_was_off_r &&
			i_serial_mode_select != MODE_OFF) begin
			tx_buffer_r <= BUFFER_RESET;
			tx_buffer_empty_r <= 1'b1;
		end else if (i_tx_write) begin
			tx_buffer_r <= (i_data_logic_invert ? ~i_tx_data : i_tx_data) & data_mask;
			tx_buffer_empty_r <= 1'b0;
		end else if (tx_state_r == ST_IDLE && !tx_buffer_empty_r && i_transmit_allow &&
			(async_mode || two_wire_mode) && !(cts_mode && cts_level_r)) begin
			tx_buffer_empty_r <= 1'b1;
		end
	end
	assign o_tx_buffer_empty_flag = tx_buffer_empty_r;

	// transmitter: one bit per sixteen ticks
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tx_state_r <= ST_IDLE;
			tx_os_r <= 4'h0;
			tx_idx_r <= 4'h0;
			tx_shift_r <= BUFFER_RESET;
			tx_stop2_r <= 1'b0;
			tx_line_r <= 1'b1;
			tx_parity_r <= 1'b0;
		end else if (!async_mode && !two_wire_mode) begin
			tx_state_r <= ST_IDLE;
			tx_line_r <= 1'b1;
		end else begin
			case (tx_state_r)
				ST_IDLE: begin
					tx_line_r <= 1'b1;
					tx_os_r <= 4'h0;
					if (!tx_buffer_empty_r && i_transmit_allow && !i_tx_write &&
						!(cts_mode && cts_level_r)) begin
						tx_shift_r <= tx_buffer_r;
						if (i_bit_order_select && char_bits == 4'h8)
							tx_shift_r <= {1'b0, tx_rev};
						tx_parity_r <= i_parity_odd;
						tx_idx_r <= 4'h0;
						tx_state_r <= ST_START;
					end
				end
				ST_START: begin
					tx_line_r <= 1'b0;
					if (tick) begin
						tx_os_r <= tx_os_r + 4'h1;
						if (tx_os_r == OVERSAMPLE_LAST) begin
							tx_state_r <= ST_DATA;
							tx_line_r <= tx_shift_r[0];
						end
					end
				end
				ST_DATA: begin
					tx_line_r <= tx_shift_r[0];
					if (tick) begin
						tx_os_r <= tx_os_r + 4'h1;
						if (tx_os_r == OVERSAMPLE_LAST) begin
							tx_parity_r <= tx_parity_r ^ tx_shift_r[0];
							tx_shift_r <= {1'b0, tx_shift_r[8:1]};
							tx_idx_r <= tx_idx_r + 4'h1;
							if (tx_idx_r == char_bits - 4'h1) begin
								tx_state_r <= i_parity_enable ? ST_PARITY : ST_STOP;
								tx_stop2_r <= i_stop_bit_count_select;
							end
						end
					end
				end
				ST_PARITY: begin
					tx_line_r <= tx_parity_r;
					if (tick) begin
						tx_os_r <= tx_os_r + 4'h1;
						if (tx_os_r == OVERSAMPLE_LAST)
							tx_state_r <= ST_STOP;
					end
				end
				default: begin
					tx_line_r <= 1'b1;
					if (tick) begin
						tx_os_r <= tx_os_r + 4'h1;
						if (tx_os_r == OVERSAMPLE_LAST) begin
							if (tx_stop2_r)
								tx_stop2_r <= 1'b0;
							else
								tx_state_r <= ST_IDLE;
						end
					end
				end
			endcase
		end
	end
	assign o_tx_shift_empty = (tx_state_r == ST_IDLE);

	// two-wire data delay: output follows only after clock held low long enough
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			low_count_r <= 4'h0;
			delayed_out_r <= 1'b1;
		end else if (clk_pin_r) begin
			low_count_r <= 4'h0;
		end else begin
			if (i_source_tick && low_count_r != 4'hF)
				low_count_r <= low_count_r + 4'h1;
			if (i_data_delay_cycles < DELAY_MIN || low_count_r >= DELAY_MAX ||
				low_count_r >= i_data_delay_cycles)
				delayed_out_r <= tx_line_r;
		end
	end

	// pin drive: two-wire data is open drain, async output always driven
	always_comb begin
		if (two_wire_mode) begin
			o_serial_out_pin = 1'b0;
			o_serial_out_pin_oe_n = delayed_out_r;
		end else begin
			o_serial_out_pin = tx_line_r ^ i_line_polarity_invert;
			o_serial_out_pin_oe_n = 1'b0;
		end
	end

	// receiver with start recheck and mid-bit sampling
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rx_state_r <= ST_IDLE;
			rx_os_r <= 4'h0;
			rx_idx_r <= 4'h0;
			rx_shift_r <= BUFFER_RESET;
			rx_parity_r <= 1'b0;
			rx_stop2_r <= 1'b0;
		end else if (!i_rx_allow || !async_mode) begin
			rx_state_r <= ST_IDLE;
		end else begin
			case (rx_state_r)
				ST_IDLE: begin
					rx_os_r <= 4'h0;
					if (!rx_line) begin
						rx_state_r <= ST_START;
						rx_idx_r <= 4'h0;
						rx_shift_r <= BUFFER_RESET;
						rx_parity_r <= i_parity_odd;
					end
				end
				ST_START: begin
					if (tick) begin
						rx_os_r <= rx_os_r + 4'h1;
						if (rx_os_r == SAMPLE_POINT && rx_line)
							rx_state_r <= ST_IDLE;
						if (rx_os_r == OVERSAMPLE_LAST)
							rx_state_r <= ST_DATA;
					end
				end
				ST_DATA: begin
					if (tick) begin
						rx_os_r <= rx_os_r + 4'h1;
						if (rx_os_r == SAMPLE_POINT) begin
							rx_shift_r[rx_idx_r] <= rx_line;
							rx_parity_r <= rx_parity_r ^ rx_line;
						end
						if (rx_os_r == OVERSAMPLE_LAST) begin
							rx_idx_r <= rx_idx_r + 4'h1;
							if (rx_idx_r == char_bits - 4'h1) begin
								rx_state_r <= i_parity_enable ? ST_PARITY : ST_STOP;
								rx_stop2_r <= i_stop_bit_count_select;
							end
						end
					end
				end
				ST_PARITY: begin
					if (tick) begin
						rx_os_r <= rx_os_r + 4'h1;
						if (rx_os_r == SAMPLE_POINT)
							rx_parity_r <= rx_parity_r ^ rx_line;
						if (rx_os_r == OVERSAMPLE_LAST)
							rx_state_r <= ST_STOP;
					end
				end
				default: begin
					if (tick) begin
						rx_os_r <= rx_os_r + 4'h1;
						if (rx_os_r == SAMPLE_POINT && rx_stop2_r && rx_line) begin
							rx_stop2_r <= 1'b0;
						end else if (rx_os_r == SAMPLE_POINT) begin
							rx_state_r <= ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	// receive buffer; completion sets flags, set wins over a same-cycle read
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rx_buffer <= BUFFER_RESET;
			rx_full_r <= 1'b0;
			o_overrun_error <= 1'b0;
			o_framing_error <= 1'b0;
			o_parity_error <= 1'b0;
		end else if (i_rx_allow && !rx_allow_prev_r) begin
			o_rx_buffer <= BUFFER_RESET;
			rx_full_r <= 1'b0;
			o_overrun_error <= 1'b0;
			o_framing_error <= 1'b0;
			o_parity_error <= 1'b0;
		end else if (rx_state_r == ST_STOP && tick && rx_os_r == SAMPLE_POINT &&
			!(rx_stop2_r && rx_line)) begin
			if (rx_full_r && !i_rx_read) begin
				o_overrun_error <= 1'b1;
			end else begin
				rx_full_r <= 1'b1;
				o_framing_error <= !rx_line;
				o_parity_error <= i_parity_enable && rx_parity_r;
			end
			if (i_bit_order_select && char_bits == 4'h8)
				o_rx_buffer <= {1'b0, rx_rev ^ {8{i_data_logic_invert}}};
			else
				o_rx_buffer <= (rx_shift_r ^ {9{i_data_logic_invert}}) & data_mask;
		end else if (i_rx_read) begin
			rx_full_r <= 1'b0;
		end
	end
	assign o_rx_complete = rx_full_r;

	// request-to-send: low when ready, high at first falling clock pin edge
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rts_r <= 1'b1;
		end else if (!i_rx_allow || rx_full_r) begin
			rts_r <= 1'b1;
		end else if (clk_pin_prev_r && !clk_pin_r) begin
			rts_r <= 1'b1;
		end else if (rx_state_r == ST_IDLE) begin
			rts_r <= 1'b0;
		end
	end
	assign o_flow_control_pin = rts_r;
	assign o_flow_control_pin_oe_n = !rts_mode;
endmodule

// ===== bench/serial_channel_properties.sv
// concurrent checks on the serial channel ports
`timescale 1ns/100ps
module serial_channel_properties
	import serial_channel_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic [2:0] i_serial_mode_select,
	input wire logic i_two_wire_mode_select,
	input wire logic i_clock_source_external_select,
	input wire logic i_handshake_disable,
	input wire logic i_handshake_direction_select,
	input wire logic i_split_handshake_active,
	input wire logic i_line_polarity_invert,
	input wire logic i_clock_delay_select,
	input wire logic i_rx_allow,
	input wire logic i_flow_control_pin,
	input wire logic o_serial_out_pin,
	input wire logic o_flow_control_pin_oe_n,
	input wire logic o_serial_clock_is_input,
	input wire logic o_tx_shift_empty,
	input wire logic [8:0] o_rx_buffer,
	input wire logic o_rx_complete,
	input wire logic o_overrun_error,
	input wire logic o_two_wire_active,
	input wire logic o_clock_delay_active
);
	logic async_m;
	logic cts_m;
	// pin roles differ in two-wire and off modes, so four of the nine checks gate on this
	assign async_m = i_serial_mode_select inside {MODE_ASYNC7, MODE_ASYNC8, MODE_ASYNC9};
	assign cts_m = async_m && !i_handshake_disable && !i_handshake_direction_select;
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_reset_n);
	// five cycles covers the three-stage input synchroniser with margin
	sequence cts_blocked;
		(cts_m && i_flow_control_pin)[*5];
	endsequence
	sequence quiet_line;
		(async_m && o_tx_shift_empty && $stable(i_line_polarity_invert))[*3];
	endsequence
	clock_pin_a: assert property (async_m |-> o_serial_clock_is_input == i_clock_source_external_select)
		else $error("clock pin role wrong");
	flow_dir_a: assert property (async_m && !i_split_handshake_active |-> o_flow_control_pin_oe_n == (i_handshake_disable || !i_handshake_direction_select))
		else $error("flow pin direction wrong");
	two_wire_a: assert property (o_two_wire_active == (i_serial_mode_select == MODE_TWO_WIRE && i_two_wire_mode_select))
		else $error("two-wire entry wrong");
	wire_options_a: assert property (o_two_wire_active |-> o_clock_delay_active == i_clock_delay_select)
		else $error("clock delay option wrong");
	idle_level_a: assert property (quiet_line |-> o_serial_out_pin == !i_line_polarity_invert)
		else $error("idle line level wrong");
	cts_hold_a: assert property (cts_blocked ##0 o_tx_shift_empty |=> o_tx_shift_empty)
		else $error("sent while clear-to-send high");
	rx_clear_a: assert property ($rose(i_rx_allow) |-> ##[1:3] (!o_rx_complete && !o_overrun_error && o_rx_buffer == BUFFER_RESET))
		else $error("receive state not cleared");
	rx_refuse_a: assert property (!i_rx_allow && !$past(i_rx_allow) |-> !$rose(o_rx_complete))
		else $error("received while disabled");
	overrun_flag_a: assert property ($rose(o_overrun_error) |-> $stable(o_rx_complete))
		else $error("complete flag moved on overrun");
endmodule
bind async_serial_channel serial_channel_properties props (.*);

// ===== bench/remote_serial_peer.sv
// remote serial transceiver model for the bench
`timescale 1ns/100ps
module remote_serial_peer (
	input wire logic i_clk,
	input wire logic i_line,
	input wire logic i_inv,
	input wire logic [3:0] i_n,
	input wire logic [15:0] i_bit,
	output logic o_line
);
	logic lv = 1'h1;
	logic [12:0] v;
	logic [12:0] got[$];
	// a real peer follows the polarity setting, idle included
	assign o_line = lv ^ i_inv;
	// start bit, then the given bits from bit 0 up, then idle
	task automatic send(input logic [12:0] b, input int n);
		lv = 1'h0;
		repeat (i_bit) @(posedge i_clk);
		#1;
		for (int k = 0; k < n; k++) begin
			lv = b[k];
			repeat (i_bit) @(posedge i_clk);
			#1;
		end
		lv = 1'h1;
	endtask
	// mid-bit recheck of the start skips glitches from setting changes
	initial forever begin
		@(posedge i_clk iff (i_line ^ i_inv) === 1'h1);
		@(posedge i_clk iff (i_line ^ i_inv) === 1'h0);
		repeat (i_bit / 2) @(posedge i_clk);
		if ((i_line ^ i_inv) === 1'h0) begin
			v = '0;
			for (int k = 0; k < i_n; k++) begin
				repeat (i_bit) @(posedge i_clk);
				v[k] = i_line ^ i_inv;
			end
			got.push_back(v);
		end
	end
endmodule

// ===== bench/tb.sv
// self-checking bench for the serial channel
`timescale 1ns/100ps
module tb;
	import serial_channel_pkg::*;
	logic i_ref_clk = 1'h0, i_reset_n = 1'h0, i_source_tick = 1'h1;
	logic [7:0] i_baud_divider = 8'h01;
	logic [2:0] i_serial_mode_select = 3'h0;
	logic i_two_wire_mode_select = 1'h0, i_clock_source_external_select = 1'h0;
	logic i_handshake_disable = 1'h1, i_handshake_direction_select = 1'h0;
	logic i_split_handshake_active = 1'h0, i_bit_order_select = 1'h0, i_data_logic_invert = 1'h0;
	logic i_line_polarity_invert = 1'h0, i_stop_bit_count_select = 1'h0, i_parity_enable = 1'h0;
	logic i_parity_odd = 1'h0, i_clock_delay_select = 1'h0, i_arbitration_update_select = 1'h0;
	logic [3:0] i_data_delay_cycles = 4'h0;
	logic i_transmit_allow = 1'h1, i_transmit_allow_write = 1'h0, i_rx_allow = 1'h0;
	logic [8:0] i_tx_data = 9'h000;
	logic i_tx_write = 1'h0, i_rx_read = 1'h0, i_serial_clock_pin = 1'h1, cts = 1'h0;
	wire logic i_serial_in_pin, i_flow_control_pin;
	logic o_serial_out_pin, o_serial_out_pin_oe_n, o_flow_control_pin, o_flow_control_pin_oe_n;
	logic o_serial_clock_is_input, o_serial_in_is_port, o_tx_buffer_empty_flag, o_tx_shift_empty;
	logic [8:0] o_rx_buffer;
	logic o_rx_complete, o_overrun_error, o_framing_error, o_parity_error, o_two_wire_active;
	logic o_arbitration_update_on_bit, o_clock_delay_active;
	logic [3:0] pn = 4'h9;
	logic [15:0] pb;
	logic [31:0] rnd = 32'h3621D3D4;
	int fails = 0, samples_checked = 0;
	int nd_t[5] = '{7, 8, 8, 9, 8};
	int ord_t[5] = '{0, 0, 1, 1, 0};
	int inv_t[5] = '{0, 0, 0, 1, 0};
	int pol_t[5] = '{0, 0, 0, 0, 1};
	int pe_t[5] = '{0, 1, 1, 0, 0};
	int po_t[5] = '{0, 0, 1, 0, 0};
	int ns_t[5] = '{1, 1, 2, 1, 1};
	// wire level of the flow pin: whoever has its enable active drives it
	assign i_flow_control_pin = o_flow_control_pin_oe_n ? cts : o_flow_control_pin;
	assign pb = 16'(OVERSAMPLE * (i_baud_divider + 1));
	async_serial_channel dut (.*);
	remote_serial_peer peer (
		.i_clk(i_ref_clk),
		.i_line(o_serial_out_pin_oe_n ? 1'h1 : o_serial_out_pin),
		.i_inv(i_line_polarity_invert),
		.i_n(pn),
		.i_bit(pb),
		.o_line(i_serial_in_pin)
	);
	initial forever #10 i_ref_clk = ~i_ref_clk;
	task automatic step(input int n = 1);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask
	task automatic wrap_up();
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [12:0] g, input logic [12:0] e);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("ERROR at %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [8:0] d);
		i_tx_data = d;
		i_tx_write = 1'h1;
		step();
		i_tx_write = 1'h0;
	endtask
	// bounded wait: 0 receive done, 1 peer got a frame, 2 overrun
	task automatic wait_for(input int c);
		int k;
		for (k = 0; k < 3000; k++) begin
			if (c == 0 ? o_rx_complete === 1'h1 : c == 1 ? peer.got.size() > 0 :
				o_overrun_error === 1'h1) break;
			step();
		end
		if (k == 3000) begin
			fails++;
			wrap_up();
		end
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {1'h0, s[31:1]} ^ (s[0] ? 32'hA3000000 : 32'h0);
	endfunction
	function automatic logic [12:0] mask(input int n);
		return 13'((1 << n) - 1);
	endfunction
	// bits after the start: data, optional parity, stop ones
	function automatic logic [12:0] frm(input logic [8:0] d, input int nd, m, pe, po);
		logic [12:0] f;
		logic p;
		f = '1;
		p = po[0];
		for (int i = 0; i < nd; i++) begin
			f[i] = (m != 0 && nd == 8) ? d[7 - i] : d[i];
			p ^= f[i];
		end
		if (pe != 0) f[nd] = p;
		return f;
	endfunction
	// a hang anywhere ends the run as a failure
	initial begin
		repeat (100000) @(posedge i_ref_clk);
		fails++;
		wrap_up();
	end
	initial begin
		logic [8:0] w;
		logic [12:0] x;
		int nd;
		int n;
		repeat (6) @(posedge i_ref_clk);
		#1;
		i_reset_n = 1'h1;
		chk(o_serial_out_pin, 1'h1);
		chk(o_tx_buffer_empty_flag, 1'h1);
		// each frame format: send one random character each way
		for (int c = 0; c < 5; c++) begin
			nd = nd_t[c];
			n = nd + pe_t[c] + ns_t[c];
			i_rx_allow = 1'h0;
			i_serial_mode_select = nd == 7 ? MODE_ASYNC7 : nd == 8 ? MODE_ASYNC8 : MODE_ASYNC9;
			i_baud_divider = 8'(c % 2 + 1);
			i_bit_order_select = ord_t[c][0];
			i_data_logic_invert = inv_t[c][0];
			i_line_polarity_invert = pol_t[c][0];
			i_parity_enable = pe_t[c][0];
			i_parity_odd = po_t[c][0];
			i_stop_bit_count_select = ns_t[c][1];
			pn = 4'(n);
			step(40);
			chk(o_serial_in_is_port, 1'h1);
			i_rx_allow = 1'h1;
			peer.got.delete();
			rnd = lfsr(rnd);
			w = rnd[8:0];
			wr(w);
			wait_for(1);
			x = frm(inv_t[c] != 0 ? ~w : w, nd, ord_t[c], pe_t[c], po_t[c]);
			chk(peer.got.pop_front() & mask(n), x & mask(n));
			rnd = lfsr(rnd);
			w = rnd[8:0];
			peer.send(frm(w, nd, ord_t[c], pe_t[c], po_t[c]), n);
			wait_for(0);
			chk(o_rx_buffer & 9'(mask(nd)), (inv_t[c] != 0 ? ~w : w) & 9'(mask(nd)));
			chk({o_parity_error, o_framing_error}, 2'h0);
			i_rx_read = 1'h1;
			step();
			i_rx_read = 1'h0;
			$display("format test %0d done", c);
		end
		// two characters with no read between them, then receive reset
		peer.send(frm(9'h0A5, 8, 0, 0, 0), 9);
		wait_for(0);
		peer.send(frm(9'h03C, 8, 0, 0, 0), 9);
		wait_for(2);
		chk(o_overrun_error, 1'h1);
		i_rx_allow = 1'h0;
		step(2);
		i_rx_allow = 1'h1;
		step(4);
		chk({o_overrun_error, o_rx_complete, o_rx_buffer}, {2'h0, BUFFER_RESET});
		$display("overrun test done");
		// pending character held by clear-to-send, then transmit buffer cleared
		cts = 1'h1;
		i_handshake_disable = 1'h0;
		step(8);
		chk(o_flow_control_pin_oe_n, 1'h1);
		peer.got.delete();
		wr(9'h155);
		step(200);
		chk({o_tx_buffer_empty_flag, o_tx_shift_empty}, 2'h1);
		i_serial_mode_select = MODE_OFF;
		step(2);
		i_serial_mode_select = MODE_ASYNC8;
		step(2);
		i_transmit_allow_write = 1'h1;
		step();
		i_transmit_allow_write = 1'h0;
		step(2);
		chk(o_tx_buffer_empty_flag, 1'h1);
		cts = 1'h0;
		step(600);
		chk(13'(peer.got.size()), 13'h0);
		i_handshake_direction_select = 1'h1;
		step(8);
		chk({o_flow_control_pin_oe_n, o_flow_control_pin}, 2'h0);
		// a serial clock fall must raise request-to-send at least briefly
		i_serial_clock_pin = 1'h0;
		x = '0;
		for (int k = 0; k < 8; k++) begin
			step();
			x[0] = x[0] | o_flow_control_pin;
		end
		chk(x, 13'h1);
		i_serial_clock_pin = 1'h1;
		i_split_handshake_active = 1'h1;
		step();
		chk(o_flow_control_pin_oe_n, 1'h1);
		i_split_handshake_active = 1'h0;
		i_handshake_disable = 1'h1;
		$display("flow control test done");
		// two-wire entry and options, then the external clock pin role
		i_clock_delay_select = 1'h1;
		i_arbitration_update_select = 1'h1;
		i_line_polarity_invert = 1'h0;
		i_data_delay_cycles = 4'h4;
		i_serial_mode_select = MODE_TWO_WIRE;
		i_two_wire_mode_select = 1'h1;
		step();
		chk({o_two_wire_active, o_clock_delay_active, o_arbitration_update_on_bit}, 3'h7);
		// data held while the clock pin is high, released some cycles after it falls
		wr(9'h000);
		step(8);
		chk(o_serial_out_pin_oe_n, 1'h1);
		i_serial_clock_pin = 1'h0;
		step(3);
		chk(o_serial_out_pin_oe_n, 1'h1);
		step(10);
		chk(o_serial_out_pin_oe_n, 1'h0);
		i_serial_clock_pin = 1'h1;
		i_two_wire_mode_select = 1'h0;
		step();
		chk(o_two_wire_active, 1'h0);
		i_serial_mode_select = MODE_ASYNC8;
		i_clock_source_external_select = 1'h1;
		step();
		chk(o_serial_clock_is_input, 1'h1);
		$display("mode test done");
		wrap_up();
	end
endmodule
